// ==== logic/ltr_bp_pulse.sv ====
`timescale 1ns/1ps

module ltr_bp_pulse
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic pinSelect,
    input  wire logic bpMatch,
    input  wire logic perfEvent,
    output logic      pin_n
);

    typedef enum logic {LTR_PIN_IDLE, LTR_PIN_ACTIVE} ltr_pin_state_t;

    ltr_pin_state_t stateReg;
    logic [3:0]     countReg;

    // ==========================================================
    // Pulse generator
    // ==========================================================
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stateReg <= LTR_PIN_IDLE;
            countReg <= 4'h0;
            pin_n    <= 1'b1;
        end
        else
        begin
            case (stateReg)
                LTR_PIN_IDLE:
                begin
                    if (pinSelect && bpMatch)
                    begin
                        pin_n    <= 1'b0; // R4
                        countReg <= 4'(ltr_pkg::LTR_PULSE_CYCLES - 1);
                        stateReg <= LTR_PIN_ACTIVE;
                    end
                    else if (pinSelect)
                        pin_n <= 1'b1; // R3
                    else
                        pin_n <= ~perfEvent; // R5
                end
                LTR_PIN_ACTIVE:
                begin
                    // Pulse runs to its end even if the select drops
                    if (countReg == 4'h0)
                    begin
                        pin_n    <= 1'b1; // R4
                        stateReg <= LTR_PIN_IDLE;
                    end
                    else
                        countReg <= countReg - 4'h1;
                end
                default:
                begin
                    pin_n    <= 1'b1;
                    stateReg <= LTR_PIN_IDLE;
                end
            endcase
        end
    end

    property p_pulse_shape;
        @(posedge clock) disable iff (!rst_n)
        (stateReg == LTR_PIN_IDLE && pinSelect && bpMatch) |=> !pin_n [*2] ##1 pin_n;
    endproperty
    a_pulse_shape: assert property (p_pulse_shape) // R4
        else $error("breakpoint pulse has wrong shape");

endmodule

// ==== logic/ltr_pkg.sv ====
package ltr_pkg;

    // ==========================================================
    // Register addresses for the special register instructions
    // ==========================================================
    localparam logic [31:0] LTR_ADDR_ENTRY_FIRST  = 32'h0000_0040;
    localparam logic [31:0] LTR_ADDR_ENTRY_LAST   = 32'h0000_0047;
    localparam logic [31:0] LTR_ADDR_TOP_POINTER  = 32'h0000_01c9;
    localparam logic [31:0] LTR_ADDR_CONTROL      = 32'h0000_01d9;
    localparam logic [31:0] LTR_ADDR_LEG_JMP_SRC  = 32'h0000_01db;
    localparam logic [31:0] LTR_ADDR_LEG_JMP_DST  = 32'h0000_01dc;
    localparam logic [31:0] LTR_ADDR_LEG_PRE_SRC  = 32'h0000_01dd;
    localparam logic [31:0] LTR_ADDR_LEG_PRE_DST  = 32'h0000_01de;

    // ==========================================================
    // Control register fields
    // ==========================================================
    localparam int          LTR_BIT_RECORD        = 0;
    localparam int          LTR_BIT_BRANCH_STEP   = 1;
    localparam int          LTR_BIT_PIN_LO        = 2;
    localparam int          LTR_BIT_TRACE_MSG     = 6;
    localparam int          LTR_BIT_MEM_TRACE     = 7;
    localparam int          LTR_BIT_FULL_IRQ      = 8;
    localparam int          LTR_PIN_COUNT         = 4;
    localparam logic [63:0] LTR_CONTROL_MASK      = 64'h0000_0000_0000_01ff;
    localparam logic [63:0] LTR_CONTROL_RESET     = 64'h0000_0000_0000_0000;

    // ==========================================================
    // Stack geometry, feature word, timing
    // ==========================================================
    localparam int          LTR_STACK_DEPTH       = 8;
    localparam int          LTR_TOP_WIDTH         = 3;
    localparam int          LTR_FEATURE_DS_BIT    = 21;
    localparam logic [31:0] LTR_FEATURE_WORD      = 32'h0020_0000;
    localparam int          LTR_CLOCK_NS          = 100;
    localparam int          LTR_PULSE_NS          = 200;
    localparam int          LTR_PULSE_CYCLES      =
        (LTR_PULSE_NS + LTR_CLOCK_NS - 1) / LTR_CLOCK_NS;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {
        LTR_BRANCH,
        LTR_INTERRUPT,
        LTR_EXCEPTION,
        LTR_DEBUG
    } ltr_kind_t;

    typedef struct packed {
        logic        valid;
        ltr_kind_t   kind;
        logic [31:0] fromAddr;
        logic [31:0] toAddr;
    } ltr_event_t;

    typedef struct packed {
        logic        req;
        logic        write;
        logic [31:0] addr;
        logic [63:0] wdata;
        logic [1:0]  cpl;
        logic        realMode;
    } ltr_msr_req_t;

    typedef struct packed {
        logic [31:0] toAddr;
        logic [31:0] fromAddr;
    } ltr_record_t;

    function automatic logic ltr_is_transfer(input ltr_event_t ev);
        return ev.valid && (ev.kind != LTR_DEBUG);
    endfunction

    function automatic logic ltr_is_trap(input ltr_event_t ev);
        return ev.valid && ((ev.kind == LTR_INTERRUPT) || (ev.kind == LTR_EXCEPTION));
    endfunction

endpackage

// ==== logic/ltr_recorder.sv ====
`timescale 1ns/1ps

// Overview of operation
// R1: Record transfers while enable bit 0 set
// R2: Bit 1 makes trap flag step branches
// R3: Pin-select bits 5-2 route breakpoint matches
// R4: Routed match pulses pin low then high
// R5: Clear select: pin shows performance events
// R6: Bit 6 sends trace message per transfer
// R7: Bit 7 stores trace messages to memory
// R8: Bit 8 interrupts when full, else wrap
// R9: Feature word bit 21 flags debug store
// R10: Eight 64-bit entries, source low, target high
// R11: Top pointer low bits index latest entry
// R12: Legacy: keep last and pre-trap jumps
// R13: Legacy: debug exception clears enable bit
// R14: Legacy control written only privileged
// R15: Legacy jump registers undefined during messages
// R16: Advance pointer before writing new record
// R17: Legacy: copy last jump before trap record
// R18: Stack and pointer read-only, readable
// R19: Pointer at 7 wraps to entry 0
module ltr_recorder
(
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic                   legacyStrap,
    input  wire ltr_pkg::ltr_msr_req_t  msrIn,
    input  wire ltr_pkg::ltr_event_t    eventIn,
    input  wire logic                   trapFlag,
    input  wire logic                   instrRetired,
    input  wire logic [3:0]             bpMatch,
    input  wire logic [3:0]             perfEvent,
    input  wire logic                   storeFull,
    output logic                        msrAck,
    output logic                        msrFault,
    output logic [63:0]                 msrRdata,
    output logic                        stepTrap,
    output logic [3:0]                  bpPin_n,
    output logic                        btmValid,
    output logic                        storeValid,
    output logic                        storeWrap,
    output logic                        bufferIrq,
    output ltr_pkg::ltr_record_t        traceRecord,
    output logic [31:0]                 featureWord
);

    // ==========================================================
    // State
    // ==========================================================
    logic                              legacyReg;
    logic                              strapDoneReg;
    logic [63:0]                       controlReg;
    logic [ltr_pkg::LTR_TOP_WIDTH-1:0] topReg;
    logic [ltr_pkg::LTR_TOP_WIDTH-1:0] topNext;
    logic [63:0]                       stackMem [ltr_pkg::LTR_STACK_DEPTH];
    logic [31:0]                       jumpSrcReg;
    logic [31:0]                       jumpDstReg;
    logic [31:0]                       preSrcReg;
    logic [31:0]                       preDstReg;

    logic                              privOk;
    logic                              ctlWrite;
    logic                              stackRecord;
    logic                              legacyRecord;
    logic                              transfer;
    logic                              storeTry;
    logic                              readHit;
    logic [63:0]                       readValue;

    // ==========================================================
    // Variant strap, caught once after reset release
    // ==========================================================
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            legacyReg    <= 1'b0;
            strapDoneReg <= 1'b0;
        end
        else if (!strapDoneReg)
        begin
            legacyReg    <= legacyStrap;
            strapDoneReg <= 1'b1;
        end
    end

    // ==========================================================
    // Decode
    // ==========================================================
    assign privOk       = (msrIn.cpl == 2'h0) || msrIn.realMode;
    assign ctlWrite     = msrIn.req && msrIn.write && privOk
                          && (msrIn.addr == ltr_pkg::LTR_ADDR_CONTROL);
    assign transfer     = ltr_pkg::ltr_is_transfer(eventIn);
    assign stackRecord  = !legacyReg && controlReg[ltr_pkg::LTR_BIT_RECORD] && transfer;
    // Frozen while messages run; contents there carry no meaning anyway
    assign legacyRecord = legacyReg && controlReg[ltr_pkg::LTR_BIT_RECORD]
                          && !controlReg[ltr_pkg::LTR_BIT_TRACE_MSG] && transfer; // R15
    assign topNext      = topReg + 3'h1; // R16 R19
    assign storeTry     = transfer && controlReg[ltr_pkg::LTR_BIT_MEM_TRACE];

    // ==========================================================
    // Control register
    // ==========================================================
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            controlReg <= ltr_pkg::LTR_CONTROL_RESET;
        else if (ctlWrite)
            controlReg <= msrIn.wdata & ltr_pkg::LTR_CONTROL_MASK; // R14
        else if (eventIn.valid && eventIn.kind == ltr_pkg::LTR_DEBUG)
            controlReg[ltr_pkg::LTR_BIT_RECORD] <= 1'b0; // R13 R1
    end

    // ==========================================================
    // Branch record stack
    // ==========================================================
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            topReg <= '0;
        else if (stackRecord)
            topReg <= topNext; // R16 R11 R19
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < ltr_pkg::LTR_STACK_DEPTH; i++)
                stackMem[i] <= 64'h0;
        end
        else if (stackRecord)
            stackMem[topNext] <= {eventIn.toAddr, eventIn.fromAddr}; // R1 R10
    end

    // ==========================================================
    // Legacy last-jump registers
    // ==========================================================
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            jumpSrcReg <= 32'h0;
            jumpDstReg <= 32'h0;
            preSrcReg  <= 32'h0;
            preDstReg  <= 32'h0;
        end
        else if (legacyRecord)
        begin
            if (ltr_pkg::ltr_is_trap(eventIn))
            begin
                preSrcReg <= jumpSrcReg; // R17
                preDstReg <= jumpDstReg; // R17
            end
            jumpSrcReg <= eventIn.fromAddr; // R12
            jumpDstReg <= eventIn.toAddr; // R12
        end
    end

    // ==========================================================
    // Register reads
    // ==========================================================
    always_comb
    begin
        readHit   = 1'b0;
        readValue = 64'h0;
        if (msrIn.addr == ltr_pkg::LTR_ADDR_CONTROL)
        begin
            readHit   = 1'b1;
            readValue = controlReg;
        end
        else if (!legacyReg && msrIn.addr >= ltr_pkg::LTR_ADDR_ENTRY_FIRST
                 && msrIn.addr <= ltr_pkg::LTR_ADDR_ENTRY_LAST)
        begin
            readHit   = 1'b1;
            readValue = stackMem[msrIn.addr[2:0]]; // R18
        end
        else if (!legacyReg && msrIn.addr == ltr_pkg::LTR_ADDR_TOP_POINTER)
        begin
            readHit   = 1'b1;
            readValue = {61'h0, topReg}; // R11 R18
        end
        else if (legacyReg)
        begin
            case (msrIn.addr)
                ltr_pkg::LTR_ADDR_LEG_JMP_SRC:
                begin
                    readHit   = 1'b1;
                    readValue = {32'h0, jumpSrcReg};
                end
                ltr_pkg::LTR_ADDR_LEG_JMP_DST:
                begin
                    readHit   = 1'b1;
                    readValue = {32'h0, jumpDstReg};
                end
                ltr_pkg::LTR_ADDR_LEG_PRE_SRC:
                begin
                    readHit   = 1'b1;
                    readValue = {32'h0, preSrcReg};
                end
                ltr_pkg::LTR_ADDR_LEG_PRE_DST:
                begin
                    readHit   = 1'b1;
                    readValue = {32'h0, preDstReg};
                end
                default:
                begin
                    readHit   = 1'b0;
                    readValue = 64'h0;
                end
            endcase
        end
    end

    // ==========================================================
    // Register answer
    // ==========================================================
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            msrAck   <= 1'b0;
            msrFault <= 1'b0;
            msrRdata <= 64'h0;
        end
        else
        begin
            msrAck <= msrIn.req;
            // Only the control register takes writes; stack writes fault
            if (msrIn.req && msrIn.write)
                msrFault <= !ctlWrite; // R14 R18
            else
                msrFault <= msrIn.req && !readHit;
            msrRdata <= (msrIn.req && !msrIn.write) ? readValue : 64'h0;
        end
    end

    // ==========================================================
    // Single step, trace messages, memory store
    // ==========================================================
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            stepTrap <= 1'b0;
        else if (controlReg[ltr_pkg::LTR_BIT_BRANCH_STEP])
            stepTrap <= trapFlag && eventIn.valid && eventIn.kind == ltr_pkg::LTR_BRANCH; // R2
        else
            stepTrap <= trapFlag && instrRetired;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            btmValid    <= 1'b0;
            traceRecord <= '0;
        end
        else
        begin
            btmValid <= transfer && controlReg[ltr_pkg::LTR_BIT_TRACE_MSG]; // R6
            if (transfer)
                traceRecord <= {eventIn.toAddr, eventIn.fromAddr};
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            storeValid <= 1'b0;
            storeWrap  <= 1'b0;
            bufferIrq  <= 1'b0;
        end
        else
        begin
            // A full buffer with the interrupt armed drops the record
            storeValid <= storeTry && !(storeFull && controlReg[ltr_pkg::LTR_BIT_FULL_IRQ]); // R7
            storeWrap  <= storeTry && storeFull && !controlReg[ltr_pkg::LTR_BIT_FULL_IRQ]; // R8
            bufferIrq  <= storeTry && storeFull && controlReg[ltr_pkg::LTR_BIT_FULL_IRQ]; // R8
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            featureWord <= 32'h0;
        else
            featureWord <= ltr_pkg::LTR_FEATURE_WORD; // R9
    end

    // ==========================================================
    // Breakpoint pins
    // ==========================================================
    for (genvar g = 0; g < ltr_pkg::LTR_PIN_COUNT; g++)
    begin : g_pin
        ltr_bp_pulse u_pulse
        (
            .clock     (clock),
            .rst_n     (rst_n),
            .pinSelect (controlReg[ltr_pkg::LTR_BIT_PIN_LO + g]), // R3
            .bpMatch   (bpMatch[g]),
            .perfEvent (perfEvent[g]),
            .pin_n     (bpPin_n[g])
        );
    end

    // ==========================================================
    // Checks
    // ==========================================================
    property p_debug_clear;
        @(posedge clock) disable iff (!rst_n)
        (eventIn.valid && eventIn.kind == ltr_pkg::LTR_DEBUG && !ctlWrite)
            |=> !controlReg[ltr_pkg::LTR_BIT_RECORD];
    endproperty
    a_debug_clear: assert property (p_debug_clear) // R13
        else $error("debug exception left recording on");

    property p_top_advance;
        @(posedge clock) disable iff (!rst_n)
        stackRecord |=> topReg == 3'($past(topReg) + 3'h1);
    endproperty
    a_top_advance: assert property (p_top_advance) // R16
        else $error("top pointer did not advance by one");

    property p_top_wrap;
        @(posedge clock) disable iff (!rst_n)
        (stackRecord && topReg == 3'h7) |=> topReg == 3'h0;
    endproperty
    a_top_wrap: assert property (p_top_wrap) // R19
        else $error("top pointer did not wrap");

    property p_entry_layout;
        @(posedge clock) disable iff (!rst_n)
        stackRecord |=> stackMem[topReg] == {$past(eventIn.toAddr), $past(eventIn.fromAddr)};
    endproperty
    a_entry_layout: assert property (p_entry_layout) // R10
        else $error("stack entry not at top or wrong layout");

    property p_message;
        @(posedge clock) disable iff (!rst_n)
        (transfer && controlReg[ltr_pkg::LTR_BIT_TRACE_MSG] && !ctlWrite) |=> btmValid;
    endproperty
    a_message: assert property (p_message) // R6
        else $error("trace message missing");

    property p_full_irq;
        @(posedge clock) disable iff (!rst_n)
        (storeTry && storeFull && controlReg[ltr_pkg::LTR_BIT_FULL_IRQ])
            |=> bufferIrq && !storeValid && !storeWrap;
    endproperty
    a_full_irq: assert property (p_full_irq) // R8
        else $error("full buffer did not interrupt");

    property p_priv_refuse;
        @(posedge clock) disable iff (!rst_n)
        (msrIn.req && msrIn.write && !privOk && !eventIn.valid)
            |=> msrFault && $stable(controlReg);
    endproperty
    a_priv_refuse: assert property (p_priv_refuse) // R14
        else $error("unprivileged write accepted");

    property p_stack_ro;
        @(posedge clock) disable iff (!rst_n)
        (msrIn.req && msrIn.write && msrIn.addr == ltr_pkg::LTR_ADDR_TOP_POINTER)
            |=> msrAck && msrFault;
    endproperty
    a_stack_ro: assert property (p_stack_ro) // R18
        else $error("write to read-only pointer not refused");

    property p_legacy_copy;
        @(posedge clock) disable iff (!rst_n)
        (legacyRecord && ltr_pkg::ltr_is_trap(eventIn))
            |=> preSrcReg == $past(jumpSrcReg) && jumpSrcReg == $past(eventIn.fromAddr);
    endproperty
    a_legacy_copy: assert property (p_legacy_copy) // R17
        else $error("pre-trap jump not copied first");

    property p_branch_step;
        @(posedge clock) disable iff (!rst_n)
        (controlReg[ltr_pkg::LTR_BIT_BRANCH_STEP] && trapFlag && !eventIn.valid)
            |=> !stepTrap;
    endproperty
    a_branch_step: assert property (p_branch_step) // R2
        else $error("stepped without a taken branch");

    property p_feature;
        @(posedge clock) disable iff (!rst_n)
        $rose(strapDoneReg) |-> ##1 featureWord[ltr_pkg::LTR_FEATURE_DS_BIT];
    endproperty
    a_feature: assert property (p_feature) // R9
        else $error("debug store feature flag missing");

endmodule

// ==== verif/ltr_store_model.sv ====
`timescale 1ns/1ps

// ==========================================
// Memory trace buffer seen from the far side
// ==========================================
module ltr_store_model
#(
    parameter int CAPACITY = 2
)
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic storeValid,
    output logic      storeFull
);
    int countReg;

    // Full is a level that holds until reset empties the buffer
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            countReg <= 0;
        else if (storeValid)
            countReg <= countReg + 1;
    end

    assign storeFull = (countReg >= CAPACITY);
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module tb_top;
    logic                  clock = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  legacyStrap = 1'b0;
    ltr_pkg::ltr_msr_req_t msrIn = '0;
    ltr_pkg::ltr_event_t   eventIn = '0;
    logic                  trapFlag = 1'b0;
    logic                  instrRetired = 1'b0;
    logic [3:0]            bpMatch = 4'h0;
    logic [3:0]            perfEvent = 4'h0;
    logic                  storeFull, msrAck, msrFault, stepTrap, btmValid;
    logic                  storeValid, storeWrap, bufferIrq;
    logic [63:0]           msrRdata;
    logic [3:0]            bpPin_n;
    ltr_pkg::ltr_record_t  traceRecord;
    logic [31:0]           featureWord;
    int                    miscompares = 0;
    int                    compares = 0;
    int                    cycles = 0;

    always #50 clock = ~clock;

    ltr_recorder dut (.clock(clock), .rst_n(rst_n), .legacyStrap(legacyStrap), .msrIn(msrIn),
        .eventIn(eventIn), .trapFlag(trapFlag), .instrRetired(instrRetired), .bpMatch(bpMatch),
        .perfEvent(perfEvent), .storeFull(storeFull), .msrAck(msrAck), .msrFault(msrFault),
        .msrRdata(msrRdata), .stepTrap(stepTrap), .bpPin_n(bpPin_n), .btmValid(btmValid),
        .storeValid(storeValid), .storeWrap(storeWrap), .bufferIrq(bufferIrq),
        .traceRecord(traceRecord), .featureWord(featureWord));

    ltr_store_model #(.CAPACITY(2)) partner (.clock(clock), .rst_n(rst_n),
        .storeValid(storeValid), .storeFull(storeFull));

    // ==========================================
    // Register and event access
    // ==========================================
    task automatic access(input logic wr, input logic [31:0] addr, input logic [63:0] data,
                          input logic [1:0] cpl, input logic rm, input logic [63:0] expData,
                          input logic expFault);
        @(negedge clock);
        msrIn = '{1'b1, wr, addr, data, cpl, rm};
        @(negedge clock);
        msrIn.req = 1'b0;
        `CHECK(msrAck, 1'b1)
        `CHECK(msrFault, expFault)
        `CHECK(msrRdata, wr ? 64'h0 : expData)
    endtask

    task automatic rdChk(input logic [31:0] addr, input logic [63:0] exp, input logic flt);
        access(1'b0, addr, 64'h0, 2'h0, 1'b0, exp, flt);
    endtask

    task automatic wrChk(input logic [31:0] addr, input logic [63:0] data, input logic flt);
        access(1'b1, addr, data, 2'h0, 1'b0, 64'h0, flt);
    endtask

    task automatic fire(input ltr_pkg::ltr_kind_t k, input logic [31:0] f, input logic [31:0] t);
        @(negedge clock);
        eventIn = '{1'b1, k, f, t};
        @(negedge clock);
        eventIn.valid = 1'b0;
    endtask

    task automatic retire();
        @(negedge clock);
        instrRetired = 1'b1;
        @(negedge clock);
        instrRetired = 1'b0;
    endtask

    task automatic restart(input logic legacy);
        rst_n = 1'b0;
        legacyStrap = legacy;
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        // First edge after release only samples the strap
        @(negedge clock);
    endtask

    task automatic give_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            give_verdict();
        end
    end

    // ==========================================
    // Scenarios
    // ==========================================
    initial
    begin
        restart(1'b0);
        rdChk(ltr_pkg::LTR_ADDR_CONTROL, 64'h0, 1'b0);
        `CHECK(featureWord[ltr_pkg::LTR_FEATURE_DS_BIT], 1'b1)
        access(1'b1, ltr_pkg::LTR_ADDR_CONTROL, 64'h1, 2'h3, 1'b0, 64'h0, 1'b1);
        wrChk(ltr_pkg::LTR_ADDR_ENTRY_FIRST, 64'h5, 1'b1);
        wrChk(ltr_pkg::LTR_ADDR_TOP_POINTER, 64'h5, 1'b1);
        rdChk(ltr_pkg::LTR_ADDR_ENTRY_FIRST, 64'h0, 1'b0);
        access(1'b1, ltr_pkg::LTR_ADDR_CONTROL, 64'hf001, 2'h3, 1'b1, 64'h0, 1'b0);
        rdChk(ltr_pkg::LTR_ADDR_CONTROL, 64'h1, 1'b0);
        for (int i = 0; i < 11; i++)
        begin
            fire(ltr_pkg::ltr_kind_t'(i == 9 ? ltr_pkg::LTR_INTERRUPT : i == 10
                 ? ltr_pkg::LTR_EXCEPTION : ltr_pkg::LTR_BRANCH), 32'h1000 + i, 32'h2000 + i);
            rdChk(ltr_pkg::LTR_ADDR_TOP_POINTER, 64'((i + 1) % 8), 1'b0);
            rdChk(ltr_pkg::LTR_ADDR_ENTRY_FIRST + 32'((i + 1) % 8),
                  {32'h2000 + i, 32'h1000 + i}, 1'b0);
        end
        fire(ltr_pkg::LTR_DEBUG, 32'h0, 32'h0);
        rdChk(ltr_pkg::LTR_ADDR_CONTROL, 64'h0, 1'b0);
        fire(ltr_pkg::LTR_BRANCH, 32'h9, 32'h9);
        rdChk(ltr_pkg::LTR_ADDR_TOP_POINTER, 64'h3, 1'b0);
        wrChk(ltr_pkg::LTR_ADDR_CONTROL, 64'hc0, 1'b0);
        fire(ltr_pkg::LTR_BRANCH, 32'haa, 32'hbb);
        `CHECK({btmValid, storeValid, traceRecord}, {2'b11, 32'hbb, 32'haa})
        fire(ltr_pkg::LTR_BRANCH, 32'hcc, 32'hdd);
        // Let the partner see two stores before it reports full
        @(negedge clock);
        fire(ltr_pkg::LTR_BRANCH, 32'hee, 32'hff);
        `CHECK({storeValid, storeWrap, bufferIrq}, 3'b110)
        wrChk(ltr_pkg::LTR_ADDR_CONTROL, 64'h1c0, 1'b0);
        fire(ltr_pkg::LTR_BRANCH, 32'h11, 32'h22);
        `CHECK({storeValid, storeWrap, bufferIrq}, 3'b001)
        wrChk(ltr_pkg::LTR_ADDR_CONTROL, 64'h2, 1'b0);
        trapFlag = 1'b1;
        fire(ltr_pkg::LTR_BRANCH, 32'h33, 32'h44);
        `CHECK({stepTrap, btmValid}, 2'b10)
        retire();
        `CHECK(stepTrap, 1'b0)
        wrChk(ltr_pkg::LTR_ADDR_CONTROL, 64'h0, 1'b0);
        retire();
        `CHECK(stepTrap, 1'b1)
        wrChk(ltr_pkg::LTR_ADDR_CONTROL, 64'h4, 1'b0);
        @(negedge clock);
        bpMatch = 4'h3;
        perfEvent = 4'h2;
        @(negedge clock);
        bpMatch = 4'h0;
        `CHECK(bpPin_n, 4'hc)
        @(negedge clock);
        `CHECK(bpPin_n, 4'hc)
        @(negedge clock);
        `CHECK(bpPin_n, 4'hd)
        restart(1'b1);
        wrChk(ltr_pkg::LTR_ADDR_CONTROL, 64'h1, 1'b0);
        fire(ltr_pkg::LTR_BRANCH, 32'h100, 32'h200);
        fire(ltr_pkg::LTR_EXCEPTION, 32'h300, 32'h400);
        rdChk(ltr_pkg::LTR_ADDR_LEG_PRE_SRC, 64'h100, 1'b0);
        rdChk(ltr_pkg::LTR_ADDR_LEG_PRE_DST, 64'h200, 1'b0);
        rdChk(ltr_pkg::LTR_ADDR_LEG_JMP_SRC, 64'h300, 1'b0);
        rdChk(ltr_pkg::LTR_ADDR_LEG_JMP_DST, 64'h400, 1'b0);
        rdChk(ltr_pkg::LTR_ADDR_TOP_POINTER, 64'h0, 1'b1);
        wrChk(ltr_pkg::LTR_ADDR_CONTROL, 64'h41, 1'b0);
        fire(ltr_pkg::LTR_BRANCH, 32'h500, 32'h600);
        rdChk(ltr_pkg::LTR_ADDR_LEG_JMP_SRC, 64'h300, 1'b0);
        give_verdict();
    end
endmodule
